// ---- fault_pkg.sv ----
// Constants, types and helpers for the dual motor fault protection block
// How it works
// - Hardware over-current stop signal turns that motor's PWM pins to high impedance.
// - Each 100 us, any U, V or W current above 0.89 A stops the motor.
// - Each 100 us, bus voltage above 28 V stops the motor.
// - Each 100 us, bus voltage below 14 V stops the motor.
// - Each 100 us, estimated speed above 3000 rpm stops the motor.
// - A protection stop halts only the faulty motor; the other keeps running.
// - Over-current limit is computed from the programmable rated RMS current.
// - Motor A and motor B carrier interrupts fire at different instants.
// - Each carrier interrupt fires every second carrier cycle, once per 100 us.
// - Stagger comes from lengthening only motor B's first carrier cycle.
// - After B's first 100 us cycle, A and B interrupts alternate 50 us apart.
// - Each motor has its own carrier interrupt output serving its own context.
// - One shared 1 ms interrupt serves startup and speed control of both motors.
// - Over-current error interrupts carry top level 15, above carrier interrupts.
// - Any protection error raises the error event and enters the error state.
// - A bus voltage fault stops PWM output of the affected motor.
package fault_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int CARRIER_US = 50;
  localparam int CARRIER_CYC = CARRIER_US * 1000 / CLK_PERIOD_NS;
  localparam int B_FIRST_US = 100;
  localparam int B_FIRST_CYC = B_FIRST_US * 1000 / CLK_PERIOD_NS;
  localparam int MONITOR_US = 100;
  localparam int MONITOR_CYC = MONITOR_US * 1000 / CLK_PERIOD_NS;
  localparam int MS_PERIOD_MS = 1;
  localparam int MS_CYC = MS_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam int MS_W = 15;

  localparam logic [15:0] OV_LIMIT_MV = 16'h6D60;
  localparam logic [15:0] UV_LIMIT_MV = 16'h36B0;
  localparam logic [15:0] SPEED_LIMIT_RPM = 16'h0BB8;
  localparam logic [15:0] RATED_RESET_MA = 16'h0276;
  localparam logic [7:0] SQRT2_MUL = 8'hB5;
  localparam int SQRT2_SHIFT = 7;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RATED = 8'h01;
  localparam logic [7:0] ADDR_STAT_A = 8'h02;
  localparam logic [7:0] ADDR_STAT_B = 8'h03;
  localparam logic [7:0] ADDR_OC_LIMIT = 8'h04;

  localparam int CTRL_CARRIER_BIT = 0;
  localparam int CTRL_RUN_A_BIT = 1;
  localparam int CTRL_RUN_B_BIT = 2;
  localparam int CTRL_CLR_A_BIT = 4;
  localparam int CTRL_CLR_B_BIT = 5;

  localparam logic [3:0] LVL_OC = 4'hF;
  localparam logic [3:0] LVL_CARRIER = 4'hC;
  localparam logic [3:0] LVL_MS = 4'hB;
  localparam logic [3:0] LVL_NONE = 4'h0;

  typedef enum logic [2:0] {
    MODE_INACTIVE = 3'b001,
    MODE_ACTIVE = 3'b010,
    MODE_ERROR = 3'b100
  } mode_e;

  typedef struct packed {
    logic over_spd;
    logic under_v;
    logic over_v;
    logic sw_oc;
    logic hw_oc;
  } err_s;

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [15:0] oc_limit_of(input logic [15:0] rated);
    logic [23:0] p;
    p = 24'(rated) * 24'(SQRT2_MUL);
    oc_limit_of = p[SQRT2_SHIFT +: 16];
  endfunction

endpackage

// ---- carrier_timer.sv ----
// Carrier cycle timer with interrupt skipping and adjustable first cycle
`timescale 1ns/1ps
module carrier_timer #(
  parameter int FIRST_CYC = 1000,
  parameter int NORMAL_CYC = 1000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  output logic tick
);

  typedef struct packed {
    logic run;
    logic odd;
    logic tick;
    logic [fault_pkg::CNT_W-1:0] cnt;
  } timer_s;

  timer_s s;
  timer_s next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!enable) begin
      next_s = '0;
    end else if (!s.run) begin
      next_s.run = 1'b1;
      next_s.cnt = fault_pkg::CNT_W'(FIRST_CYC - 1);
    end else if (s.cnt == '0) begin
      next_s.cnt = fault_pkg::CNT_W'(NORMAL_CYC - 1);
      // Skip every other carrier end
      next_s.odd = !s.odd;
      next_s.tick = s.odd;
    end else begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

// ---- limit_check.sv ----
// Threshold comparison of one motor's sampled currents, voltage and speed
`timescale 1ns/1ps
module limit_check (
  input wire logic signed [15:0] iu,
  input wire logic signed [15:0] iv,
  input wire logic signed [15:0] iw,
  input wire logic [15:0] vdc,
  input wire logic signed [15:0] speed,
  input wire logic [15:0] oc_limit,
  output logic oc,
  output logic ov,
  output logic uv,
  output logic os
);

  // Either current direction counts as over-current
  assign oc = (fault_pkg::abs16(iu) > oc_limit) ||
              (fault_pkg::abs16(iv) > oc_limit) ||
              (fault_pkg::abs16(iw) > oc_limit);
  assign ov = vdc > fault_pkg::OV_LIMIT_MV;
  assign uv = vdc < fault_pkg::UV_LIMIT_MV;
  assign os = fault_pkg::abs16(speed) > fault_pkg::SPEED_LIMIT_RPM;

endmodule

// ---- dual_motor_fault_protection.sv ----
// Top level: registers, per-motor state, protection and interrupt scheduling
`timescale 1ns/1ps
module dual_motor_fault_protection #(
  parameter int MS_CYCLES = fault_pkg::MS_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic oc_stop_a,
  input wire logic oc_stop_b,
  input wire logic signed [15:0] iu_a,
  input wire logic signed [15:0] iv_a,
  input wire logic signed [15:0] iw_a,
  input wire logic [15:0] vdc_a,
  input wire logic signed [15:0] speed_a,
  input wire logic signed [15:0] iu_b,
  input wire logic signed [15:0] iv_b,
  input wire logic signed [15:0] iw_b,
  input wire logic [15:0] vdc_b,
  input wire logic signed [15:0] speed_b,
  output logic pwm_oe_a,
  output logic pwm_oe_b,
  output logic carrier_irq_a,
  output logic carrier_irq_b,
  output logic ms_irq,
  output logic err_irq_a,
  output logic err_irq_b,
  output logic [3:0] irq_level
);

  typedef struct packed {
    logic carrier_en;
    logic run_a;
    logic run_b;
    logic [15:0] rated;
    fault_pkg::mode_e mode_a;
    fault_pkg::mode_e mode_b;
    fault_pkg::err_s flags_a;
    fault_pkg::err_s flags_b;
    logic [fault_pkg::MS_W-1:0] ms_cnt;
    logic [15:0] rdata;
    logic pwm_oe_a;
    logic pwm_oe_b;
    logic carrier_irq_a;
    logic carrier_irq_b;
    logic ms_irq;
    logic err_irq_a;
    logic err_irq_b;
    logic [3:0] irq_level;
    logic [fault_pkg::CNT_W-1:0] since_a;
    logic seen_a;
  } state_s;

  localparam state_s RESET_S = '{
    rated: fault_pkg::RATED_RESET_MA,
    mode_a: fault_pkg::MODE_INACTIVE,
    mode_b: fault_pkg::MODE_INACTIVE,
    default: '0
  };

  state_s s;
  state_s next_s;

  logic tick_a;
  logic tick_b;
  logic [15:0] oc_limit;
  logic oc_a;
  logic ov_a;
  logic uv_a;
  logic os_a;
  logic oc_b;
  logic ov_b;
  logic uv_b;
  logic os_b;
  logic wr_ctrl;
  logic act_a;
  logic act_b;
  logic inact_a;
  logic inact_b;
  logic clr_a;
  logic clr_b;
  fault_pkg::err_s new_a;
  fault_pkg::err_s new_b;

  // Mode step shared by both motors; an error outranks any user event
  function automatic fault_pkg::mode_e step_mode(
    input fault_pkg::mode_e m,
    input logic act,
    input logic inact,
    input logic clr,
    input logic err
  );
    step_mode = m;
    if (err) begin
      step_mode = fault_pkg::MODE_ERROR;
    end else begin
      unique case (m)
        fault_pkg::MODE_INACTIVE: begin
          if (act) begin
            step_mode = fault_pkg::MODE_ACTIVE;
          end
        end
        fault_pkg::MODE_ACTIVE: begin
          if (inact) begin
            step_mode = fault_pkg::MODE_INACTIVE;
          end
        end
        fault_pkg::MODE_ERROR: begin
          if (clr) begin
            step_mode = fault_pkg::MODE_INACTIVE;
          end
        end
      endcase
    end
  endfunction

  // A new error in the clearing cycle survives the clear
  function automatic fault_pkg::err_s step_flags(
    input fault_pkg::err_s f,
    input fault_pkg::err_s fresh,
    input logic clr
  );
    step_flags = clr ? fresh : (f | fresh);
  endfunction

  function automatic logic [15:0] status_word(
    input fault_pkg::mode_e m,
    input fault_pkg::err_s f
  );
    status_word = {8'h00, f, m};
  endfunction

  // Both carriers start together; only B's first cycle is stretched
  carrier_timer #(
    .FIRST_CYC(fault_pkg::CARRIER_CYC),
    .NORMAL_CYC(fault_pkg::CARRIER_CYC)
  ) u_carrier_a (
    .clk(clk),
    .resetn(resetn),
    .enable(s.carrier_en),
    .tick(tick_a)
  );

  carrier_timer #(
    .FIRST_CYC(fault_pkg::B_FIRST_CYC),
    .NORMAL_CYC(fault_pkg::CARRIER_CYC)
  ) u_carrier_b (
    .clk(clk),
    .resetn(resetn),
    .enable(s.carrier_en),
    .tick(tick_b)
  );

  limit_check u_check_a (
    .iu(iu_a),
    .iv(iv_a),
    .iw(iw_a),
    .vdc(vdc_a),
    .speed(speed_a),
    .oc_limit(oc_limit),
    .oc(oc_a),
    .ov(ov_a),
    .uv(uv_a),
    .os(os_a)
  );

  limit_check u_check_b (
    .iu(iu_b),
    .iv(iv_b),
    .iw(iw_b),
    .vdc(vdc_b),
    .speed(speed_b),
    .oc_limit(oc_limit),
    .oc(oc_b),
    .ov(ov_b),
    .uv(uv_b),
    .os(os_b)
  );

  // Limit follows the rated current register, scaled by sqrt(2)
  assign oc_limit = fault_pkg::oc_limit_of(s.rated);

  assign wr_ctrl = wr && (addr == fault_pkg::ADDR_CTRL);
  assign act_a = wr_ctrl && wdata[fault_pkg::CTRL_RUN_A_BIT];
  assign act_b = wr_ctrl && wdata[fault_pkg::CTRL_RUN_B_BIT];
  assign inact_a = wr_ctrl && !wdata[fault_pkg::CTRL_RUN_A_BIT];
  assign inact_b = wr_ctrl && !wdata[fault_pkg::CTRL_RUN_B_BIT];
  assign clr_a = wr_ctrl && wdata[fault_pkg::CTRL_CLR_A_BIT];
  assign clr_b = wr_ctrl && wdata[fault_pkg::CTRL_CLR_B_BIT];

  // Limit checks run on each motor's own 100 us carrier tick, the stop signal on every cycle, all only while driving
  always_comb begin
    new_a.hw_oc = oc_stop_a && (s.mode_a == fault_pkg::MODE_ACTIVE);
    new_a.sw_oc = tick_a && (s.mode_a == fault_pkg::MODE_ACTIVE) && oc_a;
    new_a.over_v = tick_a && (s.mode_a == fault_pkg::MODE_ACTIVE) && ov_a;
    new_a.under_v = tick_a && (s.mode_a == fault_pkg::MODE_ACTIVE) && uv_a;
    new_a.over_spd = tick_a && (s.mode_a == fault_pkg::MODE_ACTIVE) && os_a;
    new_b.hw_oc = oc_stop_b && (s.mode_b == fault_pkg::MODE_ACTIVE);
    new_b.sw_oc = tick_b && (s.mode_b == fault_pkg::MODE_ACTIVE) && oc_b;
    new_b.over_v = tick_b && (s.mode_b == fault_pkg::MODE_ACTIVE) && ov_b;
    new_b.under_v = tick_b && (s.mode_b == fault_pkg::MODE_ACTIVE) && uv_b;
    new_b.over_spd = tick_b && (s.mode_b == fault_pkg::MODE_ACTIVE) && os_b;
  end

  always_comb begin
    next_s = s;
    next_s.rdata = 16'h0000;
    next_s.ms_irq = 1'b0;
    if (wr_ctrl) begin
      next_s.carrier_en = wdata[fault_pkg::CTRL_CARRIER_BIT];
      next_s.run_a = wdata[fault_pkg::CTRL_RUN_A_BIT];
      next_s.run_b = wdata[fault_pkg::CTRL_RUN_B_BIT];
    end
    if (wr && (addr == fault_pkg::ADDR_RATED)) begin
      next_s.rated = wdata;
    end
    // Each motor advances on its own events only
    next_s.mode_a = step_mode(s.mode_a, act_a, inact_a, clr_a, |new_a);
    next_s.mode_b = step_mode(s.mode_b, act_b, inact_b, clr_b, |new_b);
    next_s.flags_a = step_flags(s.flags_a, new_a, clr_a);
    next_s.flags_b = step_flags(s.flags_b, new_b, clr_b);
    // The stop signal cuts the drive even outside the active state
    next_s.pwm_oe_a = (next_s.mode_a == fault_pkg::MODE_ACTIVE) && !oc_stop_a;
    next_s.pwm_oe_b = (next_s.mode_b == fault_pkg::MODE_ACTIVE) && !oc_stop_b;
    next_s.err_irq_a = |new_a;
    next_s.err_irq_b = |new_b;
    next_s.carrier_irq_a = tick_a;
    next_s.carrier_irq_b = tick_b;
    // Shared millisecond tick, counted in step with the carriers
    if (!s.carrier_en) begin
      next_s.ms_cnt = '0;
    end else if (s.ms_cnt == fault_pkg::MS_W'(MS_CYCLES - 1)) begin
      next_s.ms_cnt = '0;
      next_s.ms_irq = 1'b1;
    end else begin
      next_s.ms_cnt = s.ms_cnt + 1'b1;
    end
    if (new_a.hw_oc || new_a.sw_oc || new_b.hw_oc || new_b.sw_oc) begin
      next_s.irq_level = fault_pkg::LVL_OC;
    end else if (tick_a || tick_b) begin
      next_s.irq_level = fault_pkg::LVL_CARRIER;
    end else if (next_s.ms_irq) begin
      next_s.irq_level = fault_pkg::LVL_MS;
    end else begin
      next_s.irq_level = fault_pkg::LVL_NONE;
    end
    // Cycles since motor A's last carrier interrupt, saturating, for the schedule checks
    if (!s.carrier_en) begin
      next_s.since_a = '0;
      next_s.seen_a = 1'b0;
    end else if (s.carrier_irq_a) begin
      next_s.since_a = '0;
      next_s.seen_a = 1'b1;
    end else if (s.since_a != '1) begin
      next_s.since_a = s.since_a + 1'b1;
    end
    if (rd) begin
      unique case (addr)
        fault_pkg::ADDR_CTRL: begin
          next_s.rdata[fault_pkg::CTRL_CARRIER_BIT] = s.carrier_en;
          next_s.rdata[fault_pkg::CTRL_RUN_A_BIT] = s.run_a;
          next_s.rdata[fault_pkg::CTRL_RUN_B_BIT] = s.run_b;
        end
        fault_pkg::ADDR_RATED: next_s.rdata = s.rated;
        fault_pkg::ADDR_STAT_A: next_s.rdata = status_word(s.mode_a, s.flags_a);
        fault_pkg::ADDR_STAT_B: next_s.rdata = status_word(s.mode_b, s.flags_b);
        fault_pkg::ADDR_OC_LIMIT: next_s.rdata = oc_limit;
        default: next_s.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= RESET_S;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign pwm_oe_a = s.pwm_oe_a;
  assign pwm_oe_b = s.pwm_oe_b;
  assign carrier_irq_a = s.carrier_irq_a;
  assign carrier_irq_b = s.carrier_irq_b;
  assign ms_irq = s.ms_irq;
  assign err_irq_a = s.err_irq_a;
  assign err_irq_b = s.err_irq_b;
  assign irq_level = s.irq_level;

  // Helper timing for the interrupt schedule checks
  localparam int A_GAP = fault_pkg::MONITOR_CYC - 1;
  localparam int B_GAP = fault_pkg::CARRIER_CYC - 1;
  logic [fault_pkg::CNT_W-1:0] since_a;
  logic seen_a;

  assign since_a = s.since_a;
  assign seen_a = s.seen_a;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_hw_oc_hiz: assert property (
    oc_stop_a |=> !pwm_oe_a)
    else $error("PWM A still driven after hardware stop");

  a_sw_oc_stop: assert property (
    tick_a && s.mode_a == fault_pkg::MODE_ACTIVE && oc_a |=>
      s.mode_a == fault_pkg::MODE_ERROR && s.flags_a.sw_oc && !pwm_oe_a)
    else $error("Over-current on A did not stop motor A");

  a_ov_stop: assert property (
    tick_b && s.mode_b == fault_pkg::MODE_ACTIVE && ov_b |=>
      s.flags_b.over_v && s.mode_b == fault_pkg::MODE_ERROR)
    else $error("Over-voltage on B not latched");

  a_uv_stop: assert property (
    tick_a && s.mode_a == fault_pkg::MODE_ACTIVE && uv_a |=>
      s.flags_a.under_v && err_irq_a)
    else $error("Under-voltage on A not reported");

  a_os_stop: assert property (
    tick_a && s.mode_a == fault_pkg::MODE_ACTIVE && os_a |=>
      s.flags_a.over_spd && !pwm_oe_a)
    else $error("Over-speed on A did not stop motor A");

  a_other_runs: assert property (
    (|new_a) && s.mode_b == fault_pkg::MODE_ACTIVE && !(|new_b) && !wr |=>
      s.mode_b == fault_pkg::MODE_ACTIVE)
    else $error("Fault on A disturbed motor B");

  a_irq_apart: assert property (
    carrier_irq_b && seen_a |-> !carrier_irq_a && since_a == B_GAP)
    else $error("Carrier interrupts not 50 us apart");

  a_irq_skip: assert property (
    carrier_irq_a && seen_a |-> since_a == A_GAP)
    else $error("Carrier A interrupt not every 100 us");

  a_err_level: assert property (
    oc_stop_a && s.mode_a == fault_pkg::MODE_ACTIVE |=>
      irq_level == fault_pkg::LVL_OC && err_irq_a)
    else $error("Over-current interrupt not at top level");

  a_flags_hold: assert property (
    s.mode_a == fault_pkg::MODE_ERROR && !clr_a |=>
      s.mode_a == fault_pkg::MODE_ERROR &&
      (s.flags_a & $past(s.flags_a)) == $past(s.flags_a))
    else $error("Motor A error state lost without reset");

  a_ms_spacing: assert property (
    ms_irq |=> !ms_irq [*8])
    else $error("Millisecond interrupt repeated too soon");

endmodule

// ---- inverter_model.sv ----
// Behavioural three-phase inverter stage for one motor
`timescale 1ns/1ps
module inverter_model #(
  parameter logic [15:0] HW_TRIP_MA = 16'h04B0
) (
  input wire logic clk,
  input wire logic pwm_oe,
  input wire logic signed [15:0] iu_set,
  input wire logic signed [15:0] iv_set,
  input wire logic signed [15:0] iw_set,
  input wire logic [15:0] vdc_set,
  input wire logic signed [15:0] speed_set,
  output logic signed [15:0] iu,
  output logic signed [15:0] iv,
  output logic signed [15:0] iw,
  output logic [15:0] vdc,
  output logic signed [15:0] speed,
  output logic oc_stop = 1'b0
);
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction
  // Released pins carry no current, so the motor coasts and the trip falls away
  assign iu = pwm_oe ? iu_set : 16'sh0000;
  assign iv = pwm_oe ? iv_set : 16'sh0000;
  assign iw = pwm_oe ? iw_set : 16'sh0000;
  assign speed = pwm_oe ? speed_set : 16'sh0000;
  assign vdc = vdc_set;
  // Registered comparator, like a synchronised stop line
  always @(posedge clk) begin
    oc_stop <= pwm_oe && (mag(iu) > HW_TRIP_MA || mag(iv) > HW_TRIP_MA || mag(iw) > HW_TRIP_MA);
  end
endmodule

// ---- dual_motor_fault_protection_tb.sv ----
// Self-checking bench for the dual motor fault protection block
`timescale 1ns/1ps
module dual_motor_fault_protection_tb;
  localparam int MS_SMALL = 50;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic oc_stop_a, oc_stop_b, pwm_oe_a, pwm_oe_b, carrier_irq_a, carrier_irq_b;
  logic ms_irq, err_irq_a, err_irq_b;
  logic [3:0] irq_level;
  logic signed [15:0] iu_a, iv_a, iw_a, speed_a, iu_b, iv_b, iw_b, speed_b;
  logic [15:0] vdc_a, vdc_b;
  logic signed [15:0] su_a = 16'sd300;
  logic signed [15:0] sw_a = -16'sd150;
  logic signed [15:0] sspd_a = 16'sd1500;
  logic [15:0] svdc_a = 16'd24000;
  logic [15:0] svdc_b = 16'd24000;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  dual_motor_fault_protection #(.MS_CYCLES(MS_SMALL)) u_dual_motor_fault_protection (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .oc_stop_a(oc_stop_a), .oc_stop_b(oc_stop_b), .iu_a(iu_a), .iv_a(iv_a), .iw_a(iw_a),
    .vdc_a(vdc_a), .speed_a(speed_a), .iu_b(iu_b), .iv_b(iv_b), .iw_b(iw_b), .vdc_b(vdc_b),
    .speed_b(speed_b), .pwm_oe_a(pwm_oe_a), .pwm_oe_b(pwm_oe_b), .carrier_irq_a(carrier_irq_a),
    .carrier_irq_b(carrier_irq_b), .ms_irq(ms_irq), .err_irq_a(err_irq_a),
    .err_irq_b(err_irq_b), .irq_level(irq_level));
  inverter_model u_inverter_model_a (.clk(clk), .pwm_oe(pwm_oe_a), .iu_set(su_a),
    .iv_set(-16'sd150), .iw_set(sw_a), .vdc_set(svdc_a), .speed_set(sspd_a), .iu(iu_a),
    .iv(iv_a), .iw(iw_a), .vdc(vdc_a), .speed(speed_a), .oc_stop(oc_stop_a));
  inverter_model u_inverter_model_b (.clk(clk), .pwm_oe(pwm_oe_b), .iu_set(16'sd200),
    .iv_set(-16'sd100), .iw_set(-16'sd100), .vdc_set(svdc_b), .speed_set(16'sd1200),
    .iu(iu_b), .iv(iv_b), .iw(iw_b), .vdc(vdc_b), .speed(speed_b), .oc_stop(oc_stop_b));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
    logic [15:0] d;
    rd_reg(a, d);
    check(d & m, exp, "register read");
  endtask
  // Bounded wait for motor A's error event, checked where outputs have settled
  task automatic wait_err(input int n, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < n && seen !== 1'b1; i++) begin
      @(negedge clk);
      seen = err_irq_a;
    end
  endtask
  task automatic t_reset_values();
    expect_reg(fault_pkg::ADDR_RATED, 16'h0276, 16'hFFFF);
    expect_reg(fault_pkg::ADDR_OC_LIMIT, 16'h037A, 16'hFFFF);
    expect_reg(fault_pkg::ADDR_STAT_A, 16'h0001, 16'hFFFF);
    expect_reg(fault_pkg::ADDR_STAT_B, 16'h0001, 16'hFFFF);
    expect_reg(8'h10, 16'h0000, 16'hFFFF);
    check({15'h0000, pwm_oe_a}, 16'h0000, "pwm enabled at rest");
  endtask
  task automatic t_rated_limit();
    wr_reg(fault_pkg::ADDR_RATED, 16'h03E8);
    wr_reg(8'h10, 16'h1234);
    expect_reg(fault_pkg::ADDR_RATED, 16'h03E8, 16'hFFFF);
    expect_reg(fault_pkg::ADDR_OC_LIMIT, 16'h0586, 16'hFFFF);
    wr_reg(fault_pkg::ADDR_RATED, 16'h0276);
    expect_reg(fault_pkg::ADDR_OC_LIMIT, 16'h037A, 16'hFFFF);
  endtask
  task automatic t_carrier();
    int last_a;
    int last_ms;
    int n_b;
    last_a = -1;
    last_ms = -1;
    n_b = 0;
    wr_reg(fault_pkg::ADDR_CTRL, 16'h0001);
    for (int i = 0; i < 7100; i++) begin
      @(negedge clk);
      check({15'h0000, carrier_irq_a & carrier_irq_b}, 16'h0000, "carriers together");
      if (carrier_irq_a === 1'b1) begin
        if (last_a >= 0) check(16'(i - last_a), 16'd2000, "A period");
        check({12'h000, irq_level}, {12'h000, fault_pkg::LVL_CARRIER}, "carrier level");
        last_a = i;
      end
      if (carrier_irq_b === 1'b1) begin
        n_b++;
        check(16'(i - last_a), 16'd1000, "B spacing");
      end
      if (ms_irq === 1'b1) begin
        if (last_ms >= 0) check(16'(i - last_ms), 16'(MS_SMALL), "ms period");
        last_ms = i;
      end
    end
    check(16'(n_b), 16'd3, "B count");
  endtask
  task automatic t_hw_oc();
    logic seen;
    wr_reg(fault_pkg::ADDR_CTRL, 16'h0007);
    expect_reg(fault_pkg::ADDR_CTRL, 16'h0007, 16'hFFFF);
    expect_reg(fault_pkg::ADDR_STAT_A, 16'h0002, 16'hFFFF);
    @(posedge clk);
    su_a <= 16'sd1300;
    wait_err(6, seen);
    check({15'h0000, seen}, 16'h0001, "no error event");
    check({15'h0000, pwm_oe_a}, 16'h0000, "A pins still driven");
    check({12'h000, irq_level}, {12'h000, fault_pkg::LVL_OC}, "oc level");
    check({15'h0000, pwm_oe_b}, 16'h0001, "B stopped");
    @(posedge clk);
    su_a <= 16'sd300;
    repeat (2500) @(posedge clk);
    expect_reg(fault_pkg::ADDR_STAT_A, 16'h000C, 16'h000F);
    expect_reg(fault_pkg::ADDR_STAT_B, 16'h0002, 16'hFFFF);
    wr_reg(fault_pkg::ADDR_CTRL, 16'h0015);
    expect_reg(fault_pkg::ADDR_STAT_A, 16'h0001, 16'hFFFF);
  endtask
  task automatic set_a(input int k, input bit over);
    @(posedge clk);
    case (k)
      0: sw_a <= over ? -16'sd891 : -16'sd890;
      1: svdc_a <= over ? 16'd28001 : 16'd28000;
      2: svdc_a <= over ? 16'd13999 : 16'd14000;
      default: sspd_a <= over ? 16'sd3001 : 16'sd3000;
    endcase
  endtask
  // Each limit is first held exactly at its value, which must not trip
  task automatic t_sw_faults();
    logic seen;
    logic [15:0] bits [4] = '{16'h0010, 16'h0020, 16'h0040, 16'h0080};
    for (int k = 0; k < 4; k++) begin
      wr_reg(fault_pkg::ADDR_CTRL, 16'h0007);
      set_a(k, 1'b0);
      wait_err(4200, seen);
      check({15'h0000, seen}, 16'h0000, "trip at limit");
      set_a(k, 1'b1);
      wait_err(2100, seen);
      check({15'h0000, seen}, 16'h0001, "no trip above limit");
      check({15'h0000, pwm_oe_a}, 16'h0000, "A pwm still on");
      check({15'h0000, pwm_oe_b}, 16'h0001, "B stopped");
      expect_reg(fault_pkg::ADDR_STAT_A, 16'h0004 | bits[k], 16'hFFFF);
      @(posedge clk);
      sw_a <= -16'sd150;
      svdc_a <= 16'd24000;
      sspd_a <= 16'sd1500;
      wr_reg(fault_pkg::ADDR_CTRL, 16'h0015);
      expect_reg(fault_pkg::ADDR_STAT_A, 16'h0001, 16'hFFFF);
    end
  endtask
  // Over-voltage on B must stop B alone while A keeps driving
  task automatic t_fault_b();
    logic seen;
    seen = 1'b0;
    wr_reg(fault_pkg::ADDR_CTRL, 16'h0007);
    @(posedge clk);
    svdc_b <= 16'd28001;
    for (int i = 0; i < 2100 && seen !== 1'b1; i++) begin
      @(negedge clk);
      seen = err_irq_b;
    end
    check({15'h0000, seen}, 16'h0001, "no B error event");
    check({15'h0000, pwm_oe_b}, 16'h0000, "B pwm still on");
    check({15'h0000, pwm_oe_a}, 16'h0001, "A stopped by B fault");
    expect_reg(fault_pkg::ADDR_STAT_B, 16'h0024, 16'hFFFF);
    @(posedge clk);
    svdc_b <= 16'd24000;
    wr_reg(fault_pkg::ADDR_CTRL, 16'h0023);
    expect_reg(fault_pkg::ADDR_STAT_B, 16'h0001, 16'hFFFF);
    expect_reg(fault_pkg::ADDR_STAT_A, 16'h0002, 16'hFFFF);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset_values();
    t_rated_limit();
    t_carrier();
    t_hw_oc();
    t_sw_faults();
    t_fault_b();
    print_verdict();
  end
endmodule
